// File: design/sdw_engine.sv
// Write-side engine of a synchronous DRAM: bursts, truncation, precharge, auto precharge.
// Assumes commands arrive on mclk from logic in the same domain; array writes leave via a FIFO.
`timescale 1ns/1ns
module sdw_engine
    import sdw_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // Command, address, mask and write data
    input  wire sdw_req_t         req,
    input  wire logic [DQ_W-1:0]  wr_data,
    input  wire logic [DM_W-1:0]  byte_mask,
    // Mode settings
    input  wire logic [2:0]       burst_len,
    input  wire logic             write_burst_mode_bit,
    // Array write stream
    output logic                  arr_valid,
    input  wire logic             arr_ready,
    output sdw_wr_t               arr_word,
    // Status
    output logic [3:0]            bank_open,
    output logic                  burst_busy,
    output logic                  dq_oe,
    output logic                  in_stall
);
    // Burst tracking for the write in flight.
    logic [1:0]       wb_bank;
    logic [COL_W-1:0] wb_col;
    logic [7:0]       wb_left;
    logic             wb_full;
    logic             wb_auto;
    logic             wb_act;
    // Pending auto precharge per bank with its own countdown.
    logic [3:0]       ap_pend;
    logic [7:0]       ap_cnt [4];
    // Cycles since each bank was activated, saturating.
    logic [7:0]       ras_cnt [4];
    // Read burst tracking, only for auto precharge timing.
    logic [1:0]       rb_bank;
    logic [7:0]       rb_left;
    logic             rb_auto;

    wire is_wr   = (req.cmd == SDW_CMD_WR);
    wire is_rd   = (req.cmd == SDW_CMD_RD);
    wire is_pre  = (req.cmd == SDW_CMD_PRE);
    wire is_stop = (req.cmd == SDW_CMD_STOP);
    wire is_act  = (req.cmd == SDW_CMD_ACT);

    wire       bl_cont  = (burst_len == BL_FULL);
    wire [7:0] rd_len   = sdw_bl_len(burst_len);
    // Single-write mode shrinks writes to one column unless full page overrides.
    wire [7:0] wr_len   = (write_burst_mode_bit && !bl_cont) ? 8'h01 : rd_len;
    // Auto precharge only with this command's select line and a finite burst.
    wire       new_auto = req.prech_sel && !bl_cont;

    // The old burst's data element lands unless a write, read or burst stop claims the edge.
    wire keep_old   = wb_act && !is_wr && !is_rd && !is_stop;
    wire wr_element = is_wr || keep_old;
    wire [1:0]       el_bank = is_wr ? req.bank : wb_bank;
    wire [COL_W-1:0] el_col  = is_wr ? req.col : wb_col;
    wire fifo_ready;
    wire push = wr_element && (byte_mask != {DM_W{1'b1}});
    assign in_stall = !fifo_ready;

    // Remaining length after this element, for the burst that owns the next edge.
    wire [7:0] next_left = is_wr ? wr_len - 8'h01 : wb_left - 8'h01;
    wire       next_full = is_wr ? (wr_len == 8'h00) : wb_full;
    wire       next_act  = wr_element && (next_full || next_left != 8'h00);
    wire       burst_end = wr_element && !next_full && next_left == 8'h00;
    wire       next_auto = is_wr ? new_auto : wb_auto;

    sdw_fifo #(
        .WIDTH ($bits(sdw_wr_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .srst      (srst),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   ({el_bank, el_col, byte_mask, wr_data}),
        .out_valid (arr_valid),
        .out_ready (arr_ready),
        .out_data  (arr_word)
    );

    always_ff @(posedge mclk) begin
        if (srst) begin
            wb_act  <= 1'b0;
            wb_bank <= 2'h0;
            wb_col  <= '0;
            wb_left <= 8'h00;
            wb_full <= 1'b0;
            wb_auto <= 1'b0;
        end else begin
            wb_act  <= next_act;
            wb_bank <= el_bank;
            wb_col  <= el_col + 1'b1;
            wb_left <= next_left;
            wb_full <= next_full;
            wb_auto <= next_auto;
        end
    end

    // An auto-precharged write closes after recovery from its own last element, which may
    // be the write command itself, or from the column access that cuts it short.
    wire wr_ap_end  = wr_element && next_auto && burst_end;
    wire wr_ap_intr = wb_act && wb_auto && (is_rd || is_wr);
    wire rd_done    = rb_auto && rb_left == 8'h01;
    wire rd_intr    = rb_auto && rb_left > 8'h01 && (is_rd || is_wr) && req.bank != rb_bank;

    always_ff @(posedge mclk) begin
        if (srst) begin
            rb_left <= 8'h00;
            rb_bank <= 2'h0;
            rb_auto <= 1'b0;
        end else if (is_rd) begin
            rb_left <= bl_cont ? 8'h00 : rd_len;
            rb_bank <= req.bank;
            rb_auto <= new_auto;
        end else begin
            if (rb_left != 8'h00) begin
                rb_left <= rb_left - 8'h01;
            end
            // A read that has handed over its close must not arm it again later,
            // or it would shut a row that was activated afterwards.
            if (rd_done || rd_intr) begin
                rb_auto <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            bank_open <= RST_OPEN;
            ap_pend   <= 4'h0;
            for (int b = 0; b < 4; b++) begin
                ap_cnt[b]  <= 8'h00;
                ras_cnt[b] <= 8'h00;
            end
        end else begin
            for (int b = 0; b < 4; b++) begin
                if (ras_cnt[b] != 8'hFF) begin
                    ras_cnt[b] <= ras_cnt[b] + 8'h01;
                end
                if (ap_pend[b] && ap_cnt[b] != 8'h00) begin
                    ap_cnt[b] <= ap_cnt[b] - 8'h01;
                end
                // Hold the close until the row has been open long enough.
                if (ap_pend[b] && ap_cnt[b] == 8'h00 && ras_cnt[b] >= 8'(RAS_CYC)) begin
                    bank_open[b] <= 1'b0;
                    ap_pend[b]   <= 1'b0;
                end
                if (is_act && req.bank == 2'(b)) begin
                    bank_open[b] <= 1'b1;
                    ras_cnt[b]   <= 8'h00;
                end
                if (is_pre && (req.prech_sel || req.bank == 2'(b))) begin
                    bank_open[b] <= 1'b0;
                    ap_pend[b]   <= 1'b0;
                end
            end
            if (wr_ap_intr) begin
                ap_pend[wb_bank] <= 1'b1;
                ap_cnt[wb_bank]  <= 8'(WR_CYC - 1);
            end
            if (wr_ap_end) begin
                ap_pend[el_bank] <= 1'b1;
                ap_cnt[el_bank]  <= 8'(WR_CYC - 1);
            end
            if (rd_done || rd_intr) begin
                ap_pend[rb_bank] <= 1'b1;
                ap_cnt[rb_bank]  <= 8'h00;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            burst_busy <= 1'b0;
            dq_oe      <= 1'b0;
        end else begin
            burst_busy <= next_act;
            dq_oe      <= 1'b0;
        end
    end

    stop_discard_a: assert property (@(posedge mclk) disable iff (srst)
        is_stop |-> !push)
        else $error("Element pushed with burst stop.");
    read_ignore_a: assert property (@(posedge mclk) disable iff (srst)
        is_rd |-> !push ##1 !burst_busy)
        else $error("Write data taken at read.");
    mask_block_a: assert property (@(posedge mclk) disable iff (srst)
        (byte_mask == {DM_W{1'b1}}) |-> !push)
        else $error("Fully masked element stored.");
    single_mode_a: assert property (@(posedge mclk) disable iff (srst)
        (is_wr && write_burst_mode_bit && !bl_cont) |=> !burst_busy)
        else $error("Single write mode ran a burst.");
    wr_first_a: assert property (@(posedge mclk) disable iff (srst)
        (is_wr && byte_mask == '0) |-> push)
        else $error("First write element lost.");
    pre_all_a: assert property (@(posedge mclk) disable iff (srst)
        (is_pre && req.prech_sel) |=> bank_open == 4'h0)
        else $error("Precharge all left a bank open.");
    full_page_a: assert property (@(posedge mclk) disable iff (srst)
        (is_wr && bl_cont) |=> burst_busy && !wb_auto)
        else $error("Full page burst ended or set auto.");
    ras_lock_a: assert property (@(posedge mclk) disable iff (srst)
        (is_act && req.bank == 2'h0) |=> bank_open[0] [*3])
        else $error("Row closed before minimum active time.");
    done_idle_a: assert property (@(posedge mclk) disable iff (srst)
        (burst_end && !is_wr) |=> !burst_busy && !dq_oe)
        else $error("Burst kept running after last element.");
endmodule : sdw_engine

// File: design/sdw_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module sdw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp;
    logic [AW-1:0]    rp;
    logic [AW:0]      cnt;
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    assign in_ready  = (cnt != (AW+1)'(DEPTH));
    assign out_valid = (cnt != '0);
    assign out_data  = mem[rp];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
            end
            if (pop) begin
                rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
            end
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sdw_fifo

// File: design/sdw_pkg.sv
// Constants, types and command codes for the synchronous DRAM write/precharge engine.
// Assumes a single 50 MHz clock and that the controller keeps its own timing rules.
package sdw_pkg;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int T_WR_NS        = 15;
    localparam int T_RAS_NS       = 42;
    localparam int WR_CYC_RAW     = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYC         = (WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW;
    localparam int RAS_CYC        = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COL_W          = 10;
    localparam int DQ_W           = 16;
    localparam int DM_W           = 2;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [3:0] RST_OPEN = 4'h0;

    typedef enum logic [2:0] {
        SDW_CMD_NOP   = 3'b000,
        SDW_CMD_ACT   = 3'b001,
        SDW_CMD_RD    = 3'b010,
        SDW_CMD_WR    = 3'b011,
        SDW_CMD_PRE   = 3'b100,
        SDW_CMD_STOP  = 3'b101
    } sdw_cmd_t;

    typedef struct packed {
        sdw_cmd_t          cmd;
        logic [1:0]        bank;
        logic              prech_sel;
        logic [COL_W-1:0]  col;
    } sdw_req_t;

    typedef struct packed {
        logic [1:0]        bank;
        logic [COL_W-1:0]  col;
        logic [DM_W-1:0]   mask;
        logic [DQ_W-1:0]   data;
    } sdw_wr_t;

    function automatic logic [7:0] sdw_bl_len(input logic [2:0] bl);
        case (bl)
            3'h0:    sdw_bl_len = 8'h01;
            3'h1:    sdw_bl_len = 8'h02;
            3'h2:    sdw_bl_len = 8'h04;
            3'h3:    sdw_bl_len = 8'h08;
            default: sdw_bl_len = 8'h00;
        endcase
    endfunction : sdw_bl_len
endpackage : sdw_pkg

// File: testbench/sdw_ctrl_model.sv
// Behavioural memory controller that drives commands, write data and byte mask.
// Assumes the engine samples on the rising edge; this model changes lines on the falling edge.
`timescale 1ns/1ns
module sdw_ctrl_model
    import sdw_pkg::*;
(
    // Clock
    input  wire logic       mclk,
    // Command side
    output sdw_req_t        req,
    output logic [DQ_W-1:0] wr_data,
    output logic [DM_W-1:0] byte_mask
);
    initial begin
        req       = '0;
        wr_data   = 16'h0000;
        byte_mask = 2'h0;
    end

    // One command with its data and mask, held until the next call.
    // At a 20 ns period the mask around a truncating precharge is not needed.
    task automatic issue(input sdw_cmd_t c, input logic [1:0] b, input logic s,
                         input logic [COL_W-1:0] col, input logic [DQ_W-1:0] d,
                         input logic [DM_W-1:0] m);
        @(negedge mclk);
        req       = '{cmd: c, bank: b, prech_sel: s, col: col};
        wr_data   = d;
        byte_mask = m;
    endtask : issue

    // Write command carrying its first element, then the rest on NOP cycles.
    task automatic wr_run(input logic [1:0] b, input logic s, input logic [COL_W-1:0] col,
                          input logic [DQ_W-1:0] d, input int n);
        issue(SDW_CMD_WR, b, s, col, d, 2'h0);
        for (int i = 1; i < n; i++) begin
            issue(SDW_CMD_NOP, 2'h0, 1'b0, '0, d + DQ_W'(i), 2'h0);
        end
    endtask : wr_run

    // Released data lines toggle every cycle so stale data cannot pass as valid.
    task automatic idle(input int n);
        repeat (n) begin
            issue(SDW_CMD_NOP, 2'h0, 1'b0, '0, ~wr_data, 2'h0);
        end
    endtask : idle
endmodule : sdw_ctrl_model

// File: testbench/tb_sdw_engine.sv
// Self-checking bench for the write/precharge engine with a controller model in front.
// Assumes the engine's hand-over timing: one cycle from sampling edge to the FIFO output.
`timescale 1ns/1ns
module tb_sdw_engine
    import sdw_pkg::*;
;
    logic mclk, srst, wbm, arr_ready, arr_valid, burst_busy, dq_oe, in_stall;
    logic [2:0] burst_len;
    logic [3:0] bank_open;
    logic [DQ_W-1:0] wr_data;
    logic [DM_W-1:0] byte_mask;
    sdw_req_t req;
    sdw_wr_t arr_word;
    sdw_wr_t exp_q[$];
    int mismatches = 0;
    int check_count = 0;

    sdw_ctrl_model sdw_ctrl_model_i (.mclk(mclk), .req(req), .wr_data(wr_data),
                                     .byte_mask(byte_mask));
    sdw_engine #(.FIFO_DEPTH(8)) sdw_engine_i (
        .mclk(mclk), .srst(srst), .req(req), .wr_data(wr_data), .byte_mask(byte_mask),
        .burst_len(burst_len), .write_burst_mode_bit(wbm), .arr_valid(arr_valid),
        .arr_ready(arr_ready), .arr_word(arr_word), .bank_open(bank_open),
        .burst_busy(burst_busy), .dq_oe(dq_oe), .in_stall(in_stall));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic check_word(input sdw_wr_t got, input sdw_wr_t exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: word got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_val(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: status got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic expect_run(input logic [1:0] b, input logic [COL_W-1:0] col,
                              input logic [DM_W-1:0] m, input logic [DQ_W-1:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back('{bank: b, col: col + COL_W'(i), mask: m, data: d + DQ_W'(i)});
        end
    endtask : expect_run

    // Pops every expected word in order, then the FIFO must stay empty.
    task automatic drain(input string name);
        sdw_wr_t e;
        int n;
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            n = 0;
            while (arr_valid !== 1'b1 && n < 20) begin
                @(negedge mclk);
                n++;
            end
            check_word(arr_word, e);
            arr_ready = 1'b1;
            @(negedge mclk);
            arr_ready = 1'b0;
        end
        repeat (3) @(negedge mclk);
        check_val({3'h0, arr_valid}, 4'h0);
        $display("Test %s done", name);
    endtask : drain

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        conclude();
    end

    initial begin
        srst = 1'b1;
        wbm = 1'b0;
        arr_ready = 1'b0;
        burst_len = 3'h1;
        repeat (6) @(negedge mclk);
        srst = 1'b0;
        check_val(bank_open, 4'h0);
        sdw_ctrl_model_i.issue(SDW_CMD_ACT, 2'h0, 1'b0, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.issue(SDW_CMD_ACT, 2'h1, 1'b0, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.idle(3);
        check_val(bank_open, 4'h3);
        sdw_ctrl_model_i.wr_run(2'h0, 1'b0, 10'h005, 16'hA000, 2);
        sdw_ctrl_model_i.idle(4);
        expect_run(2'h0, 10'h005, 2'h0, 16'hA000, 2);
        check_val({dq_oe, burst_busy, 2'h0}, 4'h0);
        drain("burst");
        burst_len = 3'h2;
        sdw_ctrl_model_i.wr_run(2'h0, 1'b0, 10'h010, 16'hB000, 1);
        sdw_ctrl_model_i.wr_run(2'h1, 1'b0, 10'h020, 16'hB100, 1);
        sdw_ctrl_model_i.wr_run(2'h1, 1'b0, 10'h030, 16'hB200, 4);
        sdw_ctrl_model_i.idle(3);
        expect_run(2'h0, 10'h010, 2'h0, 16'hB000, 1);
        expect_run(2'h1, 10'h020, 2'h0, 16'hB100, 1);
        expect_run(2'h1, 10'h030, 2'h0, 16'hB200, 4);
        drain("write truncation");
        sdw_ctrl_model_i.wr_run(2'h0, 1'b0, 10'h040, 16'hC000, 1);
        sdw_ctrl_model_i.issue(SDW_CMD_NOP, 2'h0, 1'b0, '0, 16'hC001, 2'h3);
        sdw_ctrl_model_i.issue(SDW_CMD_NOP, 2'h0, 1'b0, '0, 16'hC002, 2'h1);
        sdw_ctrl_model_i.issue(SDW_CMD_RD, 2'h1, 1'b0, '0, 16'hC003, 2'h0);
        sdw_ctrl_model_i.idle(3);
        expect_run(2'h0, 10'h040, 2'h0, 16'hC000, 1);
        expect_run(2'h0, 10'h042, 2'h1, 16'hC002, 1);
        drain("mask and read");
        burst_len = 3'h3;
        sdw_ctrl_model_i.wr_run(2'h1, 1'b0, 10'h050, 16'hD000, 2);
        sdw_ctrl_model_i.issue(SDW_CMD_STOP, 2'h0, 1'b0, '0, 16'hD002, 2'h0);
        sdw_ctrl_model_i.idle(3);
        expect_run(2'h1, 10'h050, 2'h0, 16'hD000, 2);
        drain("burst stop");
        burst_len = BL_FULL;
        sdw_ctrl_model_i.wr_run(2'h0, 1'b0, 10'h3FE, 16'hE000, 3);
        sdw_ctrl_model_i.issue(SDW_CMD_RD, 2'h0, 1'b0, '0, 16'hE003, 2'h0);
        sdw_ctrl_model_i.idle(3);
        expect_run(2'h0, 10'h3FE, 2'h0, 16'hE000, 3);
        drain("page wrap");
        burst_len = 3'h2;
        wbm = 1'b1;
        sdw_ctrl_model_i.wr_run(2'h1, 1'b0, 10'h060, 16'hF000, 3);
        sdw_ctrl_model_i.idle(4);
        wbm = 1'b0;
        expect_run(2'h1, 10'h060, 2'h0, 16'hF000, 1);
        drain("single write mode");
        sdw_ctrl_model_i.issue(SDW_CMD_PRE, 2'h1, 1'b0, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.idle(3);
        check_val(bank_open, 4'h1);
        sdw_ctrl_model_i.issue(SDW_CMD_ACT, 2'h2, 1'b0, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.idle(3);
        check_val(bank_open, 4'h5);
        sdw_ctrl_model_i.issue(SDW_CMD_PRE, 2'h1, 1'b1, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.idle(3);
        check_val(bank_open, 4'h0);
        $display("Test precharge done");
        burst_len = 3'h0;
        sdw_ctrl_model_i.issue(SDW_CMD_ACT, 2'h0, 1'b0, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.wr_run(2'h0, 1'b1, 10'h070, 16'h1700, 1);
        sdw_ctrl_model_i.idle(1);
        check_val(bank_open, 4'h1);
        sdw_ctrl_model_i.idle(6);
        check_val(bank_open, 4'h0);
        sdw_ctrl_model_i.issue(SDW_CMD_ACT, 2'h0, 1'b0, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.idle(3);
        sdw_ctrl_model_i.wr_run(2'h0, 1'b0, 10'h071, 16'h1710, 1);
        sdw_ctrl_model_i.idle(6);
        check_val(bank_open, 4'h1);
        burst_len = BL_FULL;
        wbm = 1'b1;
        sdw_ctrl_model_i.wr_run(2'h0, 1'b1, 10'h072, 16'h1720, 1);
        sdw_ctrl_model_i.issue(SDW_CMD_RD, 2'h0, 1'b0, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.idle(6);
        check_val(bank_open, 4'h1);
        wbm = 1'b0;
        sdw_ctrl_model_i.wr_run(2'h0, 1'b1, 10'h073, 16'h1730, 1);
        sdw_ctrl_model_i.issue(SDW_CMD_RD, 2'h0, 1'b0, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.idle(6);
        check_val(bank_open, 4'h1);
        expect_run(2'h0, 10'h070, 2'h0, 16'h1700, 1);
        expect_run(2'h0, 10'h071, 2'h0, 16'h1710, 1);
        expect_run(2'h0, 10'h072, 2'h0, 16'h1720, 1);
        expect_run(2'h0, 10'h073, 2'h0, 16'h1730, 1);
        drain("auto precharge");
        // An auto-precharged read cut short by a read to another bank closes at once.
        burst_len = 3'h2;
        sdw_ctrl_model_i.issue(SDW_CMD_ACT, 2'h1, 1'b0, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.idle(3);
        sdw_ctrl_model_i.issue(SDW_CMD_RD, 2'h1, 1'b1, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.issue(SDW_CMD_RD, 2'h0, 1'b0, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.idle(2);
        check_val(bank_open, 4'h1);
        // The same read cut short by a single write to another bank.
        wbm = 1'b1;
        sdw_ctrl_model_i.idle(3);
        sdw_ctrl_model_i.issue(SDW_CMD_ACT, 2'h1, 1'b0, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.idle(3);
        sdw_ctrl_model_i.issue(SDW_CMD_RD, 2'h1, 1'b1, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.wr_run(2'h0, 1'b0, 10'h0B0, 16'h3000, 1);
        sdw_ctrl_model_i.idle(2);
        check_val(bank_open, 4'h1);
        // An auto-precharged write cut short by a read closes after recovery.
        wbm = 1'b0;
        sdw_ctrl_model_i.idle(3);
        sdw_ctrl_model_i.issue(SDW_CMD_ACT, 2'h1, 1'b0, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.idle(3);
        sdw_ctrl_model_i.wr_run(2'h1, 1'b1, 10'h0C0, 16'h3100, 2);
        sdw_ctrl_model_i.issue(SDW_CMD_RD, 2'h0, 1'b0, '0, 16'h0000, 2'h0);
        sdw_ctrl_model_i.idle(2);
        check_val(bank_open, 4'h1);
        expect_run(2'h0, 10'h0B0, 2'h0, 16'h3000, 1);
        expect_run(2'h1, 10'h0C0, 2'h0, 16'h3100, 2);
        drain("concurrent auto precharge");
        burst_len = 3'h3;
        sdw_ctrl_model_i.wr_run(2'h0, 1'b0, 10'h100, 16'h2000, 8);
        sdw_ctrl_model_i.idle(2);
        check_val({3'h0, in_stall}, 4'h1);
        expect_run(2'h0, 10'h100, 2'h0, 16'h2000, 8);
        drain("fifo fill");
        check_val({3'h0, in_stall}, 4'h0);
        conclude();
    end
endmodule : tb_sdw_engine
